// >>> rtl/rcc_pkg.sv
// Package with register map, reset values and timing for the channel config block
package rcc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_OVERRIDE    = 6'h08;
  localparam logic [5:0] IDX_CH0_SD      = 6'h12;
  localparam logic [5:0] IDX_SPARE_A     = 6'h13;
  localparam logic [5:0] IDX_SPARE_B     = 6'h14;
  localparam logic [5:0] IDX_CH1_TERM    = 6'h15;
  localparam logic [5:0] IDX_CH1_EQ      = 6'h16;
  localparam logic [5:0] IDX_CH1_SWING   = 6'h17;
  localparam logic [5:0] IDX_CH1_DEEMPH  = 6'h18;
  localparam logic [5:0] IDX_CH1_SD      = 6'h19;
  localparam logic [5:0] IDX_SPARE_C     = 6'h1A;
  localparam logic [5:0] IDX_SPARE_D     = 6'h1B;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_EQ          = 8'h2F;
  localparam logic [7:0] RST_SWING       = 8'hAD;
  localparam logic [7:0] RST_DEEMPH      = 8'h02;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OVR_TERM_BIT     = 3;
  localparam int OVR_SD_BIT       = 6;
  localparam int TERM_MODE_LSB    = 2;
  localparam int SD_ASSERT_LSB    = 2;
  localparam int SD_DEASSERT_LSB  = 0;
  localparam int SWING_LSB        = 0;
  localparam int SHORT_PROT_BIT   = 7;
  localparam int DEEMPH_LSB       = 0;
  localparam int TERM_STATE_BIT   = 7;

  // ----------------------------------------------------------------
  // Termination detect modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_HIZ        = 2'h0;
  localparam logic [1:0] MODE_AUTO_LIM   = 2'h1;
  localparam logic [1:0] MODE_AUTO_CONT  = 2'h2;
  localparam logic [1:0] MODE_FIXED_50   = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ             = 10_000_000;
  localparam longint PROBE_INTERVAL_MS  = 12;
  localparam longint PROBE_WINDOW_MS    = 600;
  localparam int PROBE_INTERVAL_CYC = int'(PROBE_INTERVAL_MS * CLK_HZ / 1000);
  localparam int PROBE_ATTEMPTS     = int'(PROBE_WINDOW_MS / PROBE_INTERVAL_MS);

  // ----------------------------------------------------------------
  // Detect states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_HIZ   = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_FOUND = 4'b0100,
    ST_STOP  = 4'b1000
  } rcc_state_e;

endpackage

// >>> rtl/rcc_term_detect.sv
// Far-end receiver probe sequencer and input termination state for one lane
`timescale 1ns/1ps
module rcc_term_detect
  import rcc_pkg::*;
#(
  parameter int PROBE_INTERVAL_CYCLES = PROBE_INTERVAL_CYC,
  parameter int ATTEMPTS              = PROBE_ATTEMPTS
)(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [1:0] mode,
  input  wire logic       receiver_found,
  output logic            probe_q,
  output logic            terminated_q
);

  localparam int CW = $clog2(PROBE_INTERVAL_CYCLES + 1);
  localparam int AW = $clog2(ATTEMPTS + 1);

  rcc_state_e     state_q, state_d;
  logic [CW-1:0]  tick_q, tick_d;
  logic [AW-1:0]  tries_q, tries_d;
  logic [1:0]     mode_q, mode_d;
  logic           probe_d;
  logic           terminated_d;
  logic           auto_mode;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    auto_mode    = (mode == MODE_AUTO_LIM) || (mode == MODE_AUTO_CONT);
    state_d      = state_q;
    tick_d       = tick_q;
    tries_d      = tries_q;
    mode_d       = mode;
    probe_d      = 1'b0;
    if (mode != mode_q)
    begin
      // Mode change restarts detection
      state_d = auto_mode ? ST_WAIT : ST_HIZ;
      tick_d  = '0;
      tries_d = '0;
    end
    else
    begin
      unique case (state_q)
        ST_HIZ:
        begin
          if (auto_mode)
            state_d = ST_WAIT;
        end
        ST_WAIT:
        begin
          if (tick_q == CW'(PROBE_INTERVAL_CYCLES - 1))
          begin
            tick_d  = '0;
            probe_d = 1'b1;
            tries_d = tries_q + AW'(1);
            if (receiver_found)
              state_d = ST_FOUND;
            else if (mode == MODE_AUTO_LIM && tries_q == AW'(ATTEMPTS - 1))
              state_d = ST_STOP;
          end
          else
            tick_d = tick_q + CW'(1);
        end
        ST_FOUND: state_d = ST_FOUND;
        ST_STOP:  state_d = ST_STOP;
        default:  state_d = ST_HIZ;
      endcase
    end
    // Fixed 50 ohm mode terminates, else auto termination follows detection
    terminated_d = (mode == MODE_FIXED_50) ||
                   (auto_mode && state_d == ST_FOUND);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q      <= ST_HIZ;
      tick_q       <= '0;
      tries_q      <= '0;
      mode_q       <= MODE_HIZ;
      probe_q      <= 1'b0;
      terminated_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      tick_q       <= tick_d;
      tries_q      <= tries_d;
      mode_q       <= mode_d;
      probe_q      <= probe_d;
      terminated_q <= terminated_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hiz_mode_open: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == MODE_HIZ) |=> !terminated_q)
    else $error("Termination on while mode is high impedance");

  a_fixed_mode_on: assert property (@(posedge clock) disable iff (!reset_n)
    (mode == MODE_FIXED_50) |=> terminated_q)
    else $error("Termination off while mode is fixed 50 ohm");

  a_attempt_limit: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == ST_STOP) |-> (tries_q == AW'(ATTEMPTS) && !probe_d && !terminated_q))
    else $error("Limited probing stopped at wrong count");

  a_found_terminates: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == ST_WAIT && probe_d && receiver_found && mode == mode_q) |=> terminated_q)
    else $error("Receiver found but input not terminated");

  c_found: cover property (@(posedge clock) disable iff (!reset_n) $rose(terminated_q));
  c_stop:  cover property (@(posedge clock) disable iff (!reset_n) state_q == ST_STOP);

endmodule

// >>> rtl/rcc_regs.sv
// Channel configuration register bank with Avalon-MM slave and termination detect
`timescale 1ns/1ps
module rcc_regs
  import rcc_pkg::*;
#(
  parameter int PROBE_INTERVAL_CYCLES = PROBE_INTERVAL_CYC,
  parameter int ATTEMPTS              = PROBE_ATTEMPTS
)(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [1:0]  termination_detect_pin,
  input  wire logic [3:0]  signal_detect_threshold_pin,
  input  wire logic        receiver_found,
  output logic             lane_one_probe,
  output logic             lane_one_input_terminated,
  output logic [7:0]       lane_one_equaliser_setting,
  output logic [2:0]       lane_one_output_swing_ratio,
  output logic             lane_one_short_protect,
  output logic [2:0]       lane_one_output_deemphasis,
  output logic [1:0]       lane_one_sd_assert_level,
  output logic [1:0]       lane_one_sd_deassert_level,
  output logic [1:0]       lane_zero_sd_assert_level,
  output logic [1:0]       lane_zero_sd_deassert_level
);

  localparam int NSLOT = 11;
  localparam int SW    = 7;

  typedef logic [7:0] rcc_byte_t;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] slot_of(input logic [5:0] idx);
    if (idx == IDX_OVERRIDE)
      slot_of = 4'h0;
    else if (idx >= IDX_CH0_SD && idx <= IDX_SPARE_D)
      slot_of = 4'(idx - IDX_CH0_SD + 6'h01);
    else
      slot_of = 4'hF;
  endfunction

  function automatic rcc_byte_t reset_of(input int s);
    unique case (s)
      int'(IDX_CH1_EQ - IDX_CH0_SD) + 1:     reset_of = RST_EQ;
      int'(IDX_CH1_SWING - IDX_CH0_SD) + 1:  reset_of = RST_SWING;
      int'(IDX_CH1_DEEMPH - IDX_CH0_SD) + 1: reset_of = RST_DEEMPH;
      default:                               reset_of = RST_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_d;

  always_comb
  begin
    pin_d = pin_q;
    if (pin_s2_q == pin_s3_q)
      pin_d = pin_s3_q;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q    <= '0;
    end
    else
    begin
      pin_s1_q <= {receiver_found, signal_detect_threshold_pin, termination_detect_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave and register storage
  // ----------------------------------------------------------------
  rcc_byte_t   regs_q [NSLOT];
  rcc_byte_t   regs_d [NSLOT];
  logic [31:0] rdata_d;
  logic        wait_d;
  logic [3:0]  slot;
  logic        mapped;
  logic        terminated;
  logic        probe;

  localparam logic [3:0] S_DEEMPH = 4'(IDX_CH1_DEEMPH - IDX_CH0_SD + 6'h01);

  always_comb
  begin
    slot    = slot_of(address);
    mapped  = (slot != 4'hF);
    wait_d  = 1'b1;
    rdata_d = readdata;
    for (int i = 0; i < NSLOT; i++)
      regs_d[i] = regs_q[i];
    if ((read || write) && waitrequest)
    begin
      // One wait state, then the answer stands for one cycle
      wait_d  = 1'b0;
      rdata_d = '0;
      if (read && mapped)
      begin
        rdata_d[7:0] = regs_q[slot];
        if (slot == S_DEEMPH)
          rdata_d[TERM_STATE_BIT] = terminated;
      end
    end
    if (write && !waitrequest && mapped && byteenable[0])
    begin
      regs_d[slot] = writedata[7:0];
      if (slot == S_DEEMPH)
        regs_d[slot][TERM_STATE_BIT] = 1'b0;
    end
  end

  generate
    for (genvar g = 0; g < NSLOT; g++)
    begin : g_reg
      always_ff @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
          regs_q[g] <= reset_of(g);
        else
          regs_q[g] <= regs_d[g];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end
    else
    begin
      waitrequest <= wait_d;
      readdata    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  rcc_byte_t ovr;
  rcc_byte_t r_ch0_sd;
  rcc_byte_t r_term;
  rcc_byte_t r_eq;
  rcc_byte_t r_swing;
  rcc_byte_t r_deemph;
  rcc_byte_t r_ch1_sd;
  logic [1:0] mode_d, mode_q;
  logic [3:0] sd_pin;
  logic [3:0] ch0_sd_d, ch1_sd_d;

  always_comb
  begin
    ovr      = regs_q[0];
    r_ch0_sd = regs_q[int'(IDX_CH0_SD - IDX_CH0_SD) + 1];
    r_term   = regs_q[int'(IDX_CH1_TERM - IDX_CH0_SD) + 1];
    r_eq     = regs_q[int'(IDX_CH1_EQ - IDX_CH0_SD) + 1];
    r_swing  = regs_q[int'(IDX_CH1_SWING - IDX_CH0_SD) + 1];
    r_deemph = regs_q[int'(IDX_CH1_DEEMPH - IDX_CH0_SD) + 1];
    r_ch1_sd = regs_q[int'(IDX_CH1_SD - IDX_CH0_SD) + 1];
    sd_pin   = pin_q[5:2];
    mode_d   = ovr[OVR_TERM_BIT] ? r_term[TERM_MODE_LSB +: 2] : pin_q[1:0];
    ch0_sd_d = ovr[OVR_SD_BIT] ? r_ch0_sd[3:0] : sd_pin;
    ch1_sd_d = ovr[OVR_SD_BIT] ? r_ch1_sd[3:0] : sd_pin;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q                      <= MODE_HIZ;
      lane_one_equaliser_setting  <= RST_EQ;
      lane_one_output_swing_ratio <= RST_SWING[SWING_LSB +: 3];
      lane_one_short_protect      <= RST_SWING[SHORT_PROT_BIT];
      lane_one_output_deemphasis  <= RST_DEEMPH[DEEMPH_LSB +: 3];
      lane_one_sd_assert_level    <= 2'h0;
      lane_one_sd_deassert_level  <= 2'h0;
      lane_zero_sd_assert_level   <= 2'h0;
      lane_zero_sd_deassert_level <= 2'h0;
      lane_one_probe              <= 1'b0;
      lane_one_input_terminated   <= 1'b0;
    end
    else
    begin
      mode_q                      <= mode_d;
      lane_one_equaliser_setting  <= r_eq;
      lane_one_output_swing_ratio <= r_swing[SWING_LSB +: 3];
      lane_one_short_protect      <= r_swing[SHORT_PROT_BIT];
      lane_one_output_deemphasis  <= r_deemph[DEEMPH_LSB +: 3];
      lane_one_sd_assert_level    <= ch1_sd_d[SD_ASSERT_LSB +: 2];
      lane_one_sd_deassert_level  <= ch1_sd_d[SD_DEASSERT_LSB +: 2];
      lane_zero_sd_assert_level   <= ch0_sd_d[SD_ASSERT_LSB +: 2];
      lane_zero_sd_deassert_level <= ch0_sd_d[SD_DEASSERT_LSB +: 2];
      lane_one_probe              <= probe;
      lane_one_input_terminated   <= terminated;
    end
  end

  // ----------------------------------------------------------------
  // Termination detect
  // ----------------------------------------------------------------
  rcc_term_detect #(
    .PROBE_INTERVAL_CYCLES (PROBE_INTERVAL_CYCLES),
    .ATTEMPTS              (ATTEMPTS)
  ) u_term (
    .clock          (clock),
    .reset_n        (reset_n),
    .mode           (mode_q),
    .receiver_found (pin_q[6]),
    .probe_q        (probe),
    .terminated_q   (terminated)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_one_wait_state: assert property (@(posedge clock) disable iff (!reset_n)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer not after exactly one wait state");

  a_eq_write_lands: assert property (@(posedge clock) disable iff (!reset_n)
    write && !waitrequest && address == IDX_CH1_EQ && byteenable[0]
    |=> ##1 lane_one_equaliser_setting == $past(writedata[7:0], 2))
    else $error("Equaliser write did not reach output");

  a_term_readback: assert property (@(posedge clock) disable iff (!reset_n)
    read && !waitrequest && address == IDX_CH1_DEEMPH
    |-> readdata[TERM_STATE_BIT] == $past(terminated))
    else $error("Termination state bit wrong on read");

  a_mode_override: assert property (@(posedge clock) disable iff (!reset_n)
    !ovr[OVR_TERM_BIT] |=> mode_q == $past(pin_q[1:0]))
    else $error("Termination mode not from pin without override");

  a_sd_override: assert property (@(posedge clock) disable iff (!reset_n)
    ovr[OVR_SD_BIT] |=> lane_one_sd_assert_level == $past(r_ch1_sd[3:2]))
    else $error("Assert threshold not from register under override");

  a_sd_pin_path: assert property (@(posedge clock) disable iff (!reset_n)
    !ovr[OVR_SD_BIT] |=> lane_zero_sd_deassert_level == $past(sd_pin[1:0]))
    else $error("De-assert threshold not from pin without override");

  a_ch0_sd_pin: assert property (@(posedge clock) disable iff (!reset_n)
    !ovr[OVR_SD_BIT] |=> lane_zero_sd_assert_level == $past(sd_pin[3:2]))
    else $error("Lane zero assert threshold not from pin without override");

  a_ch0_sd_reg: assert property (@(posedge clock) disable iff (!reset_n)
    ovr[OVR_SD_BIT] |=> lane_zero_sd_deassert_level == $past(r_ch0_sd[1:0]))
    else $error("Lane zero de-assert threshold not from its own register");

  a_deemph_bit_ro: assert property (@(posedge clock) disable iff (!reset_n)
    !regs_q[S_DEEMPH][TERM_STATE_BIT])
    else $error("Read-only termination state bit was stored");

  a_unmapped_zero: assert property (@(posedge clock) disable iff (!reset_n)
    read && !waitrequest && !mapped |-> readdata == '0)
    else $error("Unmapped read returned nonzero data");

  a_short_protect: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 lane_one_short_protect == $past(r_swing[SHORT_PROT_BIT]))
    else $error("Short protection does not follow swing bit 7");

  a_swing_field: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(r_swing[2:0]) |=> lane_one_output_swing_ratio == $past(r_swing[2:0]))
    else $error("Swing output lags swing field");

  a_deemph_field: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(r_deemph[2:0]) |=> lane_one_output_deemphasis == $past(r_deemph[2:0]))
    else $error("De-emphasis output lags field");

  c_read:     cover property (@(posedge clock) disable iff (!reset_n) read && !waitrequest);
  c_write:    cover property (@(posedge clock) disable iff (!reset_n) write && !waitrequest);
  c_override: cover property (@(posedge clock) disable iff (!reset_n) $rose(ovr[OVR_TERM_BIT]));

endmodule

// >>> testbench/tb.sv
// Self-checking testbench for the channel configuration register bank
`timescale 1ns/1ps
module tb;
  import rcc_pkg::*;
  localparam int P  = 20;
  localparam int NA = 4;
  logic        clock       = 1'b0;
  logic        reset_n     = 1'b0;
  logic [5:0]  address     = 6'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0;
  logic [3:0]  byteenable  = 4'hF;
  logic [1:0]  term_pin    = 2'h0;
  logic [3:0]  sd_pin      = 4'hB;
  logic        rx_found    = 1'b0;
  logic [31:0] readdata;
  logic [31:0] rdv;
  logic        waitrequest;
  logic        probe;
  logic        termd;
  logic        prot;
  logic [7:0]  eq;
  logic [2:0]  swing;
  logic [2:0]  deemph;
  logic [1:0]  a1;
  logic [1:0]  d1;
  logic [1:0]  a0;
  logic [1:0]  d0;
  int          err_total   = 0;
  int          checks      = 0;
  int          probe_cnt   = 0;

  rcc_regs #(.PROBE_INTERVAL_CYCLES(P), .ATTEMPTS(NA)) u_dut (
    .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .termination_detect_pin(term_pin),
    .signal_detect_threshold_pin(sd_pin), .receiver_found(rx_found),
    .lane_one_probe(probe), .lane_one_input_terminated(termd),
    .lane_one_equaliser_setting(eq), .lane_one_output_swing_ratio(swing),
    .lane_one_short_protect(prot), .lane_one_output_deemphasis(deemph),
    .lane_one_sd_assert_level(a1), .lane_one_sd_deassert_level(d1),
    .lane_zero_sd_assert_level(a0), .lane_zero_sd_deassert_level(d0)
  );

  always #50 clock = ~clock;

  // Probe pulses counted mid-cycle, away from the launching edge
  always @(negedge clock)
    if (probe === 1'b1)
      probe_cnt++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("counts: checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Avalon access: request held until waitrequest sampled low at a rising edge
  task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clock);
    address    <= a;
    read       <= rd;
    write      <= !rd;
    writedata  <= {24'h0, d};
    byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
      chk(32'h0, 32'h1);
    rdv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 4'hF);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00, 4'hF);
    chk(rdv, {24'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rc(IDX_CH0_SD, 8'h00);
    rc(IDX_CH1_TERM, 8'h00);
    rc(IDX_CH1_EQ, 8'h2F);
    rc(IDX_CH1_SWING, 8'hAD);
    rc(IDX_CH1_DEEMPH, 8'h02);
    rc(IDX_CH1_SD, 8'h00);
    rc(IDX_SPARE_A, 8'h00);
    rc(IDX_SPARE_B, 8'h00);
    rc(IDX_SPARE_C, 8'h00);
    rc(IDX_SPARE_D, 8'h00);
    chk(32'(eq), 32'h2F);
    chk(32'({prot, swing}), 32'hD);
    chk(32'(deemph), 32'h2);
    chk(32'(termd), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_rw;
    wr(IDX_CH1_EQ, 8'hA5);
    rc(IDX_CH1_EQ, 8'hA5);
    wr(IDX_CH1_SWING, 8'h2E);
    rc(IDX_CH1_SWING, 8'h2E);
    wr(IDX_CH1_DEEMPH, 8'h85);
    cyc(2);
    chk(32'(eq), 32'hA5);
    chk(32'({prot, swing}), 32'h6);
    chk(32'(deemph), 32'h5);
    rc(IDX_CH1_DEEMPH, 8'h05);
    wr(6'h3F, 8'hFF);
    rc(6'h3F, 8'h00);
    bus(1'b0, IDX_CH1_EQ, 8'h11, 4'h0);
    rc(IDX_CH1_EQ, 8'hA5);
    $display("test read write done");
  endtask

  task automatic t_thr;
    logic [1:0] c;
    cyc(8);
    chk(32'({a0, d0, a1, d1}), 32'hBB);
    wr(IDX_CH0_SD, 8'h06);
    cyc(2);
    chk(32'({a0, d0, a1, d1}), 32'hBB);
    wr(IDX_OVERRIDE, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      wr(IDX_CH1_SD, {4'h0, c, ~c});
      cyc(2);
      chk(32'({a0, d0, a1, d1}), {24'h0, 4'h6, c, ~c});
      rc(IDX_CH1_SD, {4'h0, c, ~c});
    end
    $display("test thresholds done");
  endtask

  task automatic t_term;
    wr(IDX_OVERRIDE, 8'h48);
    wr(IDX_CH1_TERM, 8'h0C);
    cyc(4);
    chk(32'(termd), 32'h1);
    rc(IDX_CH1_DEEMPH, 8'h85);
    wr(IDX_CH1_TERM, 8'h00);
    cyc(4);
    chk(32'(termd), 32'h0);
    rc(IDX_CH1_DEEMPH, 8'h05);
    wr(IDX_CH1_TERM, 8'h04);
    probe_cnt = 0;
    cyc((NA + 3) * P);
    chk(32'(probe_cnt), 32'(NA));
    chk(32'(termd), 32'h0);
    wr(IDX_CH1_TERM, 8'h08);
    probe_cnt = 0;
    cyc(3 * P - 8);
    chk(32'(probe_cnt), 32'h2);
    chk(32'(termd), 32'h0);
    rx_found <= 1'b1;
    cyc(P + 8);
    chk(32'(termd), 32'h1);
    wr(IDX_OVERRIDE, 8'h40);
    cyc(10);
    chk(32'(termd), 32'h0);
    term_pin <= 2'h3;
    cyc(10);
    chk(32'(termd), 32'h1);
    rx_found <= 1'b0;
    $display("test termination done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    t_reset;
    t_rw;
    t_thr;
    t_term;
    summarize;
  end

  initial
  begin
    cyc(5000);
    err_total++;
    summarize;
  end
endmodule
